// File: cpu_memory_map_and_status.v
// CPU memory map decode and control registers with an AHB-Lite register port
`timescale 1ns/1ns
`include "cpu_map_consts.vh"
module cpu_memory_map_and_status (
    input wire clk,
    input wire rst,
    input wire clkEn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Core address decode
    input wire [15:0] coreAddr,
    input wire coreFetch,
    output reg [7:0] memRegion,
    output reg [4:0] flashBlock,
    output reg fetchFault,
    output reg beyondFlash,
    // Vector read port
    output reg [15:0] vecAddr,
    output reg vecReq,
    input wire [7:0] vecData,
    // Core events
    input wire [2:0] resetCause,
    input wire resetEvent,
    input wire fetchStep,
    input wire [2:0] fetchLen,
    input wire branchLoad,
    input wire [15:0] branchTarget,
    input wire irqAck,
    input wire [15:0] irqVector,
    input wire breakOp,
    input wire pushStatus,
    input wire popStatus,
    input wire [7:0] popValue,
    input wire irqEnableOp,
    input wire irqDisableOp,
    input wire bankSelOp,
    input wire [1:0] bankSelValue,
    input wire aluValid,
    input wire [7:0] aluResult,
    input wire aluHalfCarry,
    input wire aluCarryValid,
    input wire aluCarry,
    input wire spLoad,
    input wire [15:0] spValue,
    input wire stackWrite,
    input wire stackRead,
    input wire irqRequest,
    input wire irqLowPriority,
    input wire irqMasked,
    input wire [15:0] shortCallTarget,
    input wire shortCallReq,
    // Status outputs
    output reg [7:0] statusWord,
    output reg [15:0] instrPointer,
    output reg [15:0] stackPointer,
    output reg [1:0] bankNumber,
    output reg irqAccept,
    output reg shortCallOk,
    output reg vectorBusy,
    output reg [7:0] pushValue
);
    // Region codes
    localparam [7:0] RG_VEC = 8'h01;
    localparam [7:0] RG_TCALL = 8'h02;
    localparam [7:0] RG_OPT = 8'h03;
    localparam [7:0] RG_FLASH = 8'h04;
    localparam [7:0] RG_RAM = 8'h05;
    localparam [7:0] RG_BANK = 8'h06;
    localparam [7:0] RG_SFR = 8'h07;
    localparam [7:0] RG_NONE = 8'h00;
    // Vector fetch states
    localparam [1:0] VS_IDLE = 2'd0;
    localparam [1:0] VS_LOW = 2'd1;
    localparam [1:0] VS_HIGH = 2'd2;

    reg [7:0] memSize_q;
    reg [1:0] vState_q;
    reg [15:0] vBase_q;
    reg [7:0] vLow_q;
    reg [7:0] eventCount_q;
    reg [15:0] dataAddr_q;
    reg aWrite_q;
    reg aRead_q;
    reg [7:0] aReg_q;

    // Flash top for the selected size
    function [15:0] flashTop;
        input [7:0] sz;
        begin
            if (sz == `MSS_16K) begin
                flashTop = `FLASH_TOP_16K;
            end else if (sz == `MSS_24K) begin
                flashTop = `FLASH_TOP_24K;
            end else begin
                flashTop = `FLASH_TOP_32K;
            end
        end
    endfunction

    // Region of a 16-bit address
    function [7:0] regionOf;
        input [15:0] a;
        input [7:0] sz;
        reg [15:0] ramFirst;
        begin
            ramFirst = (sz == `MSS_16K) ? `RAM_FIRST_SMALL : `RAM_FIRST_LARGE;
            if (a <= `VEC_LAST) begin
                regionOf = RG_VEC;
            end else if (a >= `TCALL_FIRST && a <= `TCALL_LAST) begin
                regionOf = RG_TCALL;
            end else if (a >= `OPT_FIRST && a <= `OPT_LAST) begin
                regionOf = RG_OPT;
            end else if (a <= flashTop(sz)) begin
                regionOf = RG_FLASH;
            end else if (a >= `SFR_FIRST) begin
                regionOf = RG_SFR;
            end else if (a >= `BANK_FIRST) begin
                regionOf = RG_BANK;
            end else if (a >= ramFirst) begin
                regionOf = RG_RAM;
            end else begin
                regionOf = RG_NONE;
            end
        end
    endfunction

    // Core address decode over the full 64 KB space
    always @* begin
        memRegion = regionOf(coreAddr, memSize_q);
        flashBlock = coreAddr[14:10];
        fetchFault = coreFetch && (memRegion == RG_BANK);
        beyondFlash = !coreAddr[15] && (coreAddr > flashTop(memSize_q));
    end

    // Short call range, interrupt acceptance and bank number
    always @* begin
        shortCallOk = shortCallReq && shortCallTarget >= `SCALL_FIRST
            && shortCallTarget <= `SCALL_LAST;
        irqAccept = irqRequest && statusWord[`PSW_IE] && !irqMasked
            && !(irqLowPriority && !statusWord[`PSW_ISP]);
        bankNumber = {statusWord[`PSW_BANK_SELECT_HIGH], statusWord[`PSW_BANK_SELECT_LOW]};
    end

    // Vector read port toward program flash
    always @* begin
        vectorBusy = (vState_q != VS_IDLE);
        vecReq = vectorBusy;
        vecAddr = (vState_q == VS_HIGH) ? (vBase_q | 16'h0001) : vBase_q;
    end

    // Status word as pushed on acknowledge or push
    always @* begin
        pushValue = statusWord;
    end

    // Vector fetch sequencer and instruction pointer
    always @(posedge clk) begin
        if (rst) begin
            vState_q <= VS_LOW;
            vBase_q <= `VEC_RESET;
            vLow_q <= 8'h00;
            instrPointer <= 16'h0000;
        end else if (clkEn) begin
            case (vState_q)
                VS_LOW: begin
                    vLow_q <= vecData;
                    vState_q <= VS_HIGH;
                end
                VS_HIGH: begin
                    instrPointer <= {vecData, vLow_q};
                    vState_q <= VS_IDLE;
                end
                default: begin
                    if (resetEvent) begin
                        vBase_q <= `VEC_RESET;
                        vState_q <= VS_LOW;
                    end else if (breakOp) begin
                        vBase_q <= `VEC_BREAK;
                        vState_q <= VS_LOW;
                    end else if (irqAck) begin
                        vBase_q <= {irqVector[15:1], 1'b0};
                        vState_q <= VS_LOW;
                    end else if (branchLoad) begin
                        instrPointer <= branchTarget;
                    end else if (fetchStep) begin
                        instrPointer <= instrPointer + {13'h0000, fetchLen};
                    end
                end
            endcase
        end
    end

    // Status word flags
    always @(posedge clk) begin
        if (rst) begin
            statusWord <= `PSW_RESET;
        end else if (clkEn) begin
            if (resetEvent) begin
                statusWord <= `PSW_RESET;
            end else if (popStatus) begin
                statusWord <= popValue;
            end else if (irqAck || breakOp) begin
                statusWord[`PSW_IE] <= 1'b0;
            end else begin
                if (irqDisableOp) statusWord[`PSW_IE] <= 1'b0;
                else if (irqEnableOp) statusWord[`PSW_IE] <= 1'b1;
                if (bankSelOp) begin
                    statusWord[`PSW_BANK_SELECT_HIGH] <= bankSelValue[1];
                    statusWord[`PSW_BANK_SELECT_LOW] <= bankSelValue[0];
                end
                if (aluValid) begin
                    statusWord[`PSW_Z] <= (aluResult == 8'h00);
                    statusWord[`PSW_AC] <= aluHalfCarry;
                end
                if (aluCarryValid) statusWord[`PSW_CY] <= aluCarry;
            end
        end
    end

    // Stack pointer, no reset value
    always @(posedge clk) begin
        if (clkEn) begin
            if (spLoad) stackPointer <= spValue;
            else if (stackWrite) stackPointer <= stackPointer - 16'h0001;
            else if (stackRead) stackPointer <= stackPointer + 16'h0001;
        end
    end

    // AHB-Lite slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Read data for one register offset; holes read as zero
    function [31:0] readWord;
        input [7:0] off;
        begin
            if ({24'h0, off} == `REG_PSW) begin
                readWord = {24'h0, statusWord};
            end else if ({24'h0, off} == `REG_MSS) begin
                readWord = {24'h0, memSize_q};
            end else if ({24'h0, off} == `REG_PC) begin
                readWord = {16'h0, instrPointer};
            end else if ({24'h0, off} == `REG_SP) begin
                readWord = {16'h0, stackPointer};
            end else if ({24'h0, off} == `REG_EVT) begin
                readWord = {24'h0, eventCount_q};
            end else if ({24'h0, off} == `REG_DEC) begin
                readWord = {8'h0, regionOf(dataAddr_q, memSize_q), 11'h0, dataAddr_q[14:10]};
            end else if ({24'h0, off} == `REG_DADDR) begin
                readWord = {16'h0, dataAddr_q};
            end else begin
                readWord = 32'h00000000;
            end
        end
    endfunction

    // Address phase capture and read data
    always @(posedge clk) begin
        if (rst) begin
            aWrite_q <= 1'b0;
            aRead_q <= 1'b0;
            aReg_q <= 8'h00;
            hrdata <= 32'h00000000;
        end else if (clkEn) begin
            if (hready) begin
                aWrite_q <= hsel && htrans[1] && hwrite;
                aRead_q <= hsel && htrans[1] && !hwrite;
                aReg_q <= haddr[7:0];
                if (hsel && htrans[1] && !hwrite) begin
                    hrdata <= readWord(haddr[7:0]);
                end
            end
        end
    end

    // Data phase writes; only haddr[7:0] is decoded, so each register aliases every 256 bytes
    always @(posedge clk) begin
        if (rst) begin
            memSize_q <= `MSS_RESET;
            dataAddr_q <= 16'h0000;
        end else if (clkEn) begin
            if (aWrite_q && {24'h0, aReg_q} == `REG_MSS) begin
                memSize_q <= hwdata[7:0];
            end else if (aWrite_q && {24'h0, aReg_q} == `REG_DADDR) begin
                dataAddr_q <= hwdata[15:0];
            end
        end
    end

    // Count of vector-taking events, readable by software
    always @(posedge clk) begin
        if (rst) begin
            eventCount_q <= 8'h00;
        end else if (clkEn) begin
            if (resetEvent || irqAck || breakOp) begin
                eventCount_q <= eventCount_q + 8'h01;
            end
        end
    end
endmodule // cpu_memory_map_and_status

// File: cpu_map_consts.vh
// Constants for the CPU address decode and control state block
`ifndef CPU_MAP_CONSTS_VH
`define CPU_MAP_CONSTS_VH
`define MSS_RESET 8'hcf
`define MSS_16K 8'h04
`define MSS_24K 8'hc6
`define MSS_32K 8'hc8
`define FLASH_TOP_16K 16'h3fff
`define FLASH_TOP_24K 16'h5fff
`define FLASH_TOP_32K 16'h7fff
`define BLOCK_SHIFT 10
`define VEC_LAST 16'h003f
`define VEC_RESET 16'h0000
`define VEC_LVI 16'h0004
`define VEC_BREAK 16'h003e
`define TCALL_FIRST 16'h0040
`define TCALL_LAST 16'h007f
`define OPT_FIRST 16'h0080
`define OPT_LAST 16'h0084
`define SCALL_FIRST 16'h0800
`define SCALL_LAST 16'h0fff
`define RAM_FIRST_SMALL 16'hfc00
`define RAM_FIRST_LARGE 16'hfb00
`define RAM_LAST 16'hfeff
`define BANK_FIRST 16'hfee0
`define SFR_FIRST 16'hff00
`define PSW_RESET 8'h02
`define PSW_IE 7
`define PSW_Z 6
`define PSW_BANK_SELECT_HIGH 5
`define PSW_AC 4
`define PSW_BANK_SELECT_LOW 3
`define PSW_ISP 1
`define PSW_CY 0
`define REG_PSW 32'h00
`define REG_MSS 32'h04
`define REG_PC 32'h08
`define REG_SP 32'h0c
`define REG_EVT 32'h10
`define REG_DEC 32'h14
`define REG_DADDR 32'h18
`endif

// File: cpu_map_properties.sv
// Port assertions for the map decode and status block
`timescale 1ns/1ns
module cpu_map_properties (
    input wire clk,
    input wire rst,
    input wire clkEn,
    input wire [15:0] coreAddr,
    input wire coreFetch,
    input wire [4:0] flashBlock,
    input wire fetchFault,
    input wire [7:0] statusWord,
    input wire [1:0] bankNumber,
    input wire irqAccept,
    input wire irqLowPriority,
    input wire irqEnableOp,
    input wire irqDisableOp,
    input wire irqAck,
    input wire breakOp,
    input wire popStatus,
    input wire shortCallReq,
    input wire [15:0] shortCallTarget,
    input wire shortCallOk
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Decode and flag relations
    block_number_a: assert property (flashBlock == coreAddr[14:10]) else $error("block wrong");
    bank_fault_a: assert property (fetchFault == (coreFetch && coreAddr >= 16'hfee0 && coreAddr <= 16'hfeff))
        else $error("fetch fault wrong");
    ie_clear_a: assert property (clkEn && (irqDisableOp || irqAck) && !popStatus |=> !statusWord[7])
        else $error("enable kept");
    ie_set_a: assert property (clkEn && irqEnableOp && !(irqDisableOp || irqAck || breakOp || popStatus)
        |=> statusWord[7]) else $error("enable not set");
    irq_gate_a: assert property (!statusWord[7] |-> !irqAccept) else $error("accept when off");
    low_prio_a: assert property (irqLowPriority && !statusWord[1] |-> !irqAccept) else $error("low accepted");
    bank_map_a: assert property (bankNumber == {statusWord[5], statusWord[3]}) else $error("bank wrong");
    short_call_a: assert property (shortCallReq |-> shortCallOk == (shortCallTarget[15:11] == 5'h01))
        else $error("short call wrong");
endmodule // cpu_map_properties
bind cpu_memory_map_and_status cpu_map_properties u_cpu_map_properties (.clk(clk), .rst(rst), .clkEn(clkEn),
    .coreAddr(coreAddr), .coreFetch(coreFetch), .flashBlock(flashBlock), .fetchFault(fetchFault),
    .statusWord(statusWord), .bankNumber(bankNumber), .irqAccept(irqAccept), .irqLowPriority(irqLowPriority),
    .irqEnableOp(irqEnableOp), .irqDisableOp(irqDisableOp), .irqAck(irqAck), .breakOp(breakOp),
    .popStatus(popStatus), .shortCallReq(shortCallReq), .shortCallTarget(shortCallTarget), .shortCallOk(shortCallOk));

// File: cpu_flash_model.sv
// Vector bytes of program flash behind the vector read port
`timescale 1ns/1ns
module cpu_flash_model (
    input wire clk,
    input wire vecReq,
    input wire [15:0] vecAddr,
    output logic [7:0] vecData
);
    // Entry n holds (40h+n):(20h+n), low byte even; idle port toggles
    assign vecData = !vecReq ? {8{clk}} : (vecAddr[0] ? 8'h40 : 8'h20) + vecAddr[5:1];
endmodule // cpu_flash_model

// File: cpu_memory_map_and_status_tb.sv
// Self-checking bench for the map decode and status block
`timescale 1ns/1ns
`include "cpu_map_consts.vh"
module cpu_memory_map_and_status_tb;
    logic clk, rst, clkEn, hwrite, hreadyout, hresp, coreFetch, vecReq, resetEvent, fetchStep, branchLoad, irqAck;
    logic breakOp, pushStatus, popStatus, irqEnableOp, irqDisableOp, bankSelOp, aluValid, aluHalfCarry, aluCarry;
    logic aluCarryValid, spLoad, stackWrite, stackRead, irqRequest, irqLowPriority, irqMasked, shortCallReq;
    logic irqAccept, shortCallOk, vectorBusy, fetchFault, beyondFlash;
    logic [1:0] htrans, bankSelValue, bankNumber;
    logic [2:0] fetchLen;
    logic [4:0] flashBlock;
    logic [7:0] vecData, popValue, aluResult, memRegion, statusWord, pushValue, v;
    logic [15:0] coreAddr, vecAddr, branchTarget, irqVector, spValue, shortCallTarget, instrPointer, stackPointer, a, p;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] mss [3] = '{`MSS_16K, `MSS_24K, `MSS_32K};
    logic [15:0] edges [8] = '{16'h003f, 16'h0040, 16'h007f, 16'h0084, 16'h0085, 16'h3fff, 16'hfbff, 16'hfee0};
    int failures = 0, tests_run = 0, cyc = 0;
    cpu_memory_map_and_status u_cpu_memory_map_and_status (.hsel(1'b1), .hsize(3'b010), .hready(hreadyout),
        .resetCause(3'b000), .*);
    cpu_flash_model u_cpu_flash_model (.clk(clk), .vecReq(vecReq), .vecAddr(vecAddr), .vecData(vecData));
    // Clock and hang limit
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            final_report();
        end
    end
    task chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single word transfer
    task bus(input logic w, input logic [31:0] ad, d);
        htrans <= 2'b10;
        haddr <= ad;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Let a pulse be taken, then drop all pulses but irqDisableOp and pushStatus
    task step;
        @(posedge clk);
        {fetchStep, branchLoad, irqAck, breakOp, popStatus, irqEnableOp, bankSelOp, aluValid} <= '0;
        {aluCarryValid, spLoad, stackWrite, stackRead, resetEvent} <= '0;
        @(posedge clk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function logic [15:0] vexp(input logic [15:0] x);
        return {8'h40 + x[8:1], 8'h20 + x[8:1]};
    endfunction
    function logic [15:0] top(input logic [7:0] m);
        return m == `MSS_16K ? `FLASH_TOP_16K : m == `MSS_24K ? `FLASH_TOP_24K : `FLASH_TOP_32K;
    endfunction
    function logic [7:0] region(input logic [15:0] x, input logic [7:0] m);
        if (x >= `SFR_FIRST) return 7;
        if (x >= `BANK_FIRST) return 6;
        if (x >= (m == `MSS_16K ? `RAM_FIRST_SMALL : `RAM_FIRST_LARGE)) return 5;
        if (x > top(m)) return 0;
        if (x <= `VEC_LAST) return 1;
        if (x <= `TCALL_LAST) return 2;
        return x <= `OPT_LAST ? 3 : 4;
    endfunction
    initial begin
        {rst, clkEn, shortCallReq} = 3'b111;
        {hwrite, coreFetch, resetEvent, fetchStep, branchLoad, irqAck, breakOp, pushStatus, popStatus} = '0;
        {irqEnableOp, irqDisableOp, bankSelOp, aluValid, aluHalfCarry, aluCarry, aluCarryValid, spLoad} = '0;
        {stackWrite, stackRead, irqRequest, irqLowPriority, irqMasked, htrans, bankSelValue, fetchLen} = '0;
        {popValue, aluResult, coreAddr, branchTarget, irqVector, spValue, shortCallTarget, haddr, hwdata} = '0;
        void'($urandom(32'h4f48e37b));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(statusWord, `PSW_RESET);
        chk(instrPointer, vexp(`VEC_RESET));
        bus(0, `REG_MSS, 0);
        chk(rd, `MSS_RESET);
        bus(0, 32'h40, 0);
        chk(rd, 0);
        $display("reset test done");
        foreach (mss[i]) begin
            bus(1, `REG_MSS, mss[i]);
            bus(0, `REG_MSS, 0);
            chk(rd, mss[i]);
            for (int k = 0; k < 120; k++) begin
                a = k < 8 ? edges[k] : 16'($urandom);
                coreAddr <= a;
                v = 8'($urandom_range(255));
                coreFetch <= v[0];
                p = 16'($urandom_range(16'h1fff));
                shortCallTarget <= p;
                {irqRequest, irqLowPriority, irqMasked} <= 3'($urandom);
                @(posedge clk);
                chk(flashBlock, a[14:10]);
                chk(fetchFault, v[0] && a >= `BANK_FIRST && a <= `RAM_LAST);
                chk(shortCallOk, p >= `SCALL_FIRST && p <= `SCALL_LAST);
                chk(irqAccept, 0);
                chk(beyondFlash, a < 16'h8000 && a > top(mss[i]));
                if (!(a < 16'h8000 && a > top(mss[i]))) chk(memRegion, region(a, mss[i]));
            end
        end
        $display("decode test done");
        irqEnableOp <= 1;
        step;
        chk(statusWord[7], 1);
        irqVector <= `VEC_LVI;
        irqAck <= 1;
        step;
        repeat (3) @(posedge clk);
        chk(statusWord[7], 0);
        chk(instrPointer, vexp(`VEC_LVI));
        breakOp <= 1;
        step;
        repeat (3) @(posedge clk);
        chk(instrPointer, vexp(`VEC_BREAK));
        for (int b = 0; b < 4; b++) begin
            bankSelOp <= 1;
            bankSelValue <= 2'(b);
            step;
            chk({statusWord[5], statusWord[3]}, b);
        end
        for (int k = 0; k < 8; k++) begin
            v = k < 2 ? 8'h00 : 8'($urandom_range(255, 1));
            {aluResult, aluHalfCarry, aluCarry, aluValid, aluCarryValid} <= {v, k[0], k[1], 2'b11};
            step;
            chk({statusWord[6], statusWord[4], statusWord[0]}, {v == 0, k[0], k[1]});
        end
        v = {1'b1, 7'($urandom)};
        popValue <= v;
        popStatus <= 1;
        step;
        chk(pushValue, v);
        for (int k = 0; k < 8; k++) begin
            {irqRequest, irqLowPriority, irqMasked} <= 3'(k);
            @(posedge clk);
            chk(irqAccept, k[2] && !k[0] && !(k[1] && !v[1]));
        end
        p = instrPointer;
        fetchLen <= 3'd3;
        fetchStep <= 1;
        step;
        chk(instrPointer, p + 16'd3);
        branchTarget <= 16'h1234;
        branchLoad <= 1;
        spValue <= 16'hfee0;
        spLoad <= 1;
        step;
        chk(instrPointer, 16'h1234);
        stackWrite <= 1;
        step;
        chk(stackPointer, 16'hfedf);
        stackRead <= 1;
        step;
        chk(stackPointer, 16'hfee0);
        p = instrPointer;
        clkEn <= 0;
        fetchLen <= 3'd1;
        fetchStep <= 1;
        step;
        chk(instrPointer, p);
        clkEn <= 1;
        bus(0, `REG_EVT, 0);
        chk(rd, 2);
        resetEvent <= 1;
        step;
        repeat (3) @(posedge clk);
        chk(statusWord, `PSW_RESET);
        chk(instrPointer, vexp(`VEC_RESET));
        bus(0, `REG_PSW, 0);
        chk(rd, `PSW_RESET);
        bus(0, `REG_EVT, 0);
        chk(rd, 3);
        a = 16'($urandom);
        bus(1, `REG_DADDR, a);
        bus(0, `REG_DEC, 0);
        chk(rd, {8'h0, region(a, `MSS_32K), 11'h0, a[14:10]});
        $display("status test done");
        final_report();
    end
endmodule // cpu_memory_map_and_status_tb
